// ===== rtl/i2c_addr_baud_fifo_ctrl.sv
// I2C enable, own-address match, baud divider and dual FIFO control
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_map.svh"

module i2c_addr_baud_fifo_ctrl (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus_start,
  input  wire logic        bus_byte_done,
  input  wire logic [7:0]  bus_rx_byte,
  input  wire logic        bus_error_flag,
  input  wire logic        tx_pop,
  output logic      [7:0]  tx_data,
  output logic             tx_avail,
  output logic             addr_ack,
  output logic             slave_active,
  output logic             serial_tick,
  output logic             link_run,
  output logic             tx_irq,
  output logic             rx_irq
);
  import i2c_ctrl_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic                 if_enable;
  logic [6:0]           addr_compare_mask;
  logic                 own_addr_detect_on;
  logic [6:0]           own_addr_value;
  logic [14:0]          baud_value;
  logic                 lost_detect_on;
  logic                 rx_idle_detect_on;
  logic                 tx_refill_request;
  logic                 tx_refill_irq_on;
  logic                 fifo_role_select;
  logic                 retx_lost_flag;
  logic                 read_ptr_restore;
  logic                 fifo_a_on;
  logic                 fifo_b_on;
  logic                 rx_irq_on;
  logic [`PTR_W-1:0]    saved_ptr;
  logic [7:0]           mem_a [`FIFO_DEPTH];
  logic [7:0]           mem_b [`FIFO_DEPTH];
  logic [`PTR_W-1:0]    wp_a, rp_a, wp_b, rp_b;
  logic [`CNT_W-1:0]    cnt_a, cnt_b;

  // Byte-wide I2C reads a bus bit in a fixed number of divider ticks
  logic [14:0]          reload_cnt;
  logic [1:0]           tick_cnt;
  logic                 bit_tick;
  logic [3:0]           idle_bits;
  logic                 idle_seen;
  addr_state_t          addr_state;
  logic                 addr_match;

  wire access = psel && penable;
  wire wr     = access && pwrite;
  wire rd     = access && !pwrite;

  function automatic logic hit(input logic [11:0] ofs);
    hit = (paddr == ofs);
  endfunction

  assign pready  = 1'b1;
  wire mapped = hit(`ADDR_MASK_OFS) || hit(`OWN_ADDR_OFS) || hit(`BAUD_OFS) ||
                hit(`FIFO_UPPER_OFS) || hit(`FIFO_LOWER_OFS) || hit(`CTRL_OFS) ||
                hit(`STATUS_OFS) || hit(`TXWR_OFS) || hit(`RXRD_OFS);
  assign pslverr = access && !mapped;

  // ****************************************************************
  // Role mapping
  // ****************************************************************
  wire tx_is_b = fifo_role_select;
  wire [`CNT_W-1:0] tx_cnt = tx_is_b ? cnt_b : cnt_a;
  wire [`CNT_W-1:0] rx_cnt = tx_is_b ? cnt_a : cnt_b;
  wire [`PTR_W-1:0] tx_rp  = tx_is_b ? rp_b : rp_a;
  wire [`PTR_W-1:0] tx_wp  = tx_is_b ? wp_b : wp_a;
  wire tx_on = tx_is_b ? fifo_b_on : fifo_a_on;
  wire rx_on = tx_is_b ? fifo_a_on : fifo_b_on;

  wire wr_lo   = wr && hit(`FIFO_LOWER_OFS);
  wire wr_up   = wr && hit(`FIFO_UPPER_OFS);
  wire clr_a   = wr_lo && pwdata[`LO_CLEAR_A_BIT];
  wire clr_b   = wr_lo && pwdata[`LO_CLEAR_B_BIT];
  wire tx_clr  = tx_is_b ? clr_b : clr_a;
  wire save_wr = wr_lo && pwdata[`LO_SAVE_BIT];
  wire tx_full = (tx_cnt == `CNT_W'(`FIFO_DEPTH));
  // Restore owns the pointer while busy; only resets may write then
  wire tx_push = wr && hit(`TXWR_OFS) && !tx_full && !read_ptr_restore && if_enable;
  wire rx_push = bus_byte_done && if_enable && rx_on && (addr_state == slave_st) &&
                 (rx_cnt != `CNT_W'(`FIFO_DEPTH));
  wire do_pop  = tx_pop && tx_avail && if_enable;
  wire rx_rd   = rd && hit(`RXRD_OFS) && (rx_cnt != '0);
  wire restore_go = wr_lo && pwdata[`LO_RESTORE_BIT] && !retx_lost_flag;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      if_enable         <= 1'b0;
      addr_compare_mask <= 7'(`MASK_RESET);
      own_addr_detect_on <= 1'b0;
      baud_value        <= '0;
      rx_irq_on         <= 1'b0;
    end else begin
      // Bus error is not looked at here on purpose
      if (wr && hit(`ADDR_MASK_OFS)) begin
        if_enable         <= pwdata[`MASK_ENABLE_BIT];
        addr_compare_mask <= pwdata[6:0];
      end
      if (wr && hit(`OWN_ADDR_OFS)) begin
        own_addr_detect_on <= pwdata[`OWN_DETECT_BIT];
      end
      if (wr && hit(`BAUD_OFS)) begin
        baud_value <= pwdata[14:0];
      end
      if (wr && hit(`CTRL_OFS)) begin
        rx_irq_on <= pwdata[0];
      end
    end
  end

  // ****************************************************************
  // Address match
  // ****************************************************************
  assign addr_match = own_addr_detect_on &&
    (((bus_rx_byte[7:1] ^ own_addr_value) & addr_compare_mask) == 7'h00);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_state     <= idle_st;
      own_addr_value <= '0;
      addr_ack       <= 1'b0;
    end else begin
      addr_ack <= 1'b0;
      if (wr && hit(`OWN_ADDR_OFS)) begin
        own_addr_value <= pwdata[6:0];
      end
      if (!if_enable) begin
        addr_state <= idle_st;
      end else if (bus_start) begin
        addr_state <= addr_st;
      end else begin
        case (addr_state)
          addr_st: begin
            if (bus_byte_done) begin
              if (addr_match) begin
                addr_state     <= slave_st;
                addr_ack       <= 1'b1;
                own_addr_value <= bus_rx_byte[7:1];
              end else begin
                addr_state <= idle_st;
              end
            end
          end
          default: ;
        endcase
      end
    end
  end
  assign slave_active = (addr_state == slave_st) && if_enable;
  assign link_run     = if_enable;

  // ****************************************************************
  // Baud reload counter
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reload_cnt  <= '0;
      serial_tick <= 1'b0;
      tick_cnt    <= '0;
      bit_tick    <= 1'b0;
    end else begin
      serial_tick <= 1'b0;
      bit_tick    <= 1'b0;
      if (wr && hit(`BAUD_OFS)) begin
        reload_cnt <= pwdata[14:0];
        tick_cnt   <= '0;
      end else if (!if_enable) begin
        reload_cnt <= baud_value;
        tick_cnt   <= '0;
      end else if (reload_cnt == '0) begin
        reload_cnt  <= baud_value;
        serial_tick <= 1'b1;
        if (tick_cnt == `TICKS_PER_BIT) begin
          tick_cnt <= '0;
          bit_tick <= 1'b1;
        end else begin
          tick_cnt <= tick_cnt + 2'd1;
        end
      end else begin
        reload_cnt <= reload_cnt - 15'd1;
      end
    end
  end

  // ****************************************************************
  // FIFO control flags
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lost_detect_on    <= 1'b0;
      rx_idle_detect_on <= 1'b0;
      tx_refill_request <= 1'b1;
      tx_refill_irq_on  <= 1'b0;
      fifo_role_select  <= 1'b0;
      fifo_a_on         <= 1'b0;
      fifo_b_on         <= 1'b0;
    end else begin
      if (wr_up) begin
        lost_detect_on    <= pwdata[`UP_LOST_ON_BIT];
        rx_idle_detect_on <= pwdata[`UP_IDLE_ON_BIT];
        tx_refill_irq_on  <= pwdata[`UP_IRQ_ON_BIT];
        if (tx_refill_request) begin
          fifo_role_select <= pwdata[`UP_ROLE_BIT];
        end
      end
      if (wr_lo) begin
        fifo_a_on <= pwdata[`LO_ON_A_BIT];
        fifo_b_on <= pwdata[`LO_ON_B_BIT];
      end
      // Set beats clear: empty or reset wins over a software 0
      if (tx_cnt == '0 || tx_clr) begin
        tx_refill_request <= 1'b1;
      end else if (tx_full) begin
        tx_refill_request <= 1'b0;
      end else if (wr_up && !pwdata[`UP_REFILL_BIT]) begin
        tx_refill_request <= 1'b0;
      end
    end
  end
  assign tx_irq = tx_refill_request && tx_refill_irq_on;

  // ****************************************************************
  // Pointers, save, restore and lost flag
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_a <= '0; rp_a <= '0; cnt_a <= '0;
      wp_b <= '0; rp_b <= '0; cnt_b <= '0;
      saved_ptr        <= '0;
      retx_lost_flag   <= 1'b0;
      read_ptr_restore <= 1'b0;
    end else begin
      read_ptr_restore <= 1'b0;
      if (save_wr) begin
        saved_ptr <= tx_rp;
      end
      if (lost_detect_on && tx_push && (tx_wp == saved_ptr)) begin
        retx_lost_flag <= 1'b1;
      end else if (clr_a || clr_b || save_wr) begin
        retx_lost_flag <= 1'b0;
      end
      if (restore_go) begin
        read_ptr_restore <= 1'b1;
      end
      // FIFO A
      if (clr_a) begin
        wp_a <= '0; rp_a <= '0; cnt_a <= '0;
      end else if (!tx_is_b) begin
        if (read_ptr_restore) begin
          rp_a  <= saved_ptr;
          cnt_a <= `CNT_W'(wp_a - saved_ptr);
        end else begin
          if (tx_push) wp_a <= wp_a + 4'h1;
          if (do_pop) rp_a <= rp_a + 4'h1;
          cnt_a <= cnt_a + `CNT_W'(tx_push) - `CNT_W'(do_pop);
        end
      end else begin
        if (rx_push) wp_a <= wp_a + 4'h1;
        if (rx_rd) rp_a <= rp_a + 4'h1;
        cnt_a <= cnt_a + `CNT_W'(rx_push) - `CNT_W'(rx_rd);
      end
      // FIFO B
      if (clr_b) begin
        wp_b <= '0; rp_b <= '0; cnt_b <= '0;
      end else if (tx_is_b) begin
        if (read_ptr_restore) begin
          rp_b  <= saved_ptr;
          cnt_b <= `CNT_W'(wp_b - saved_ptr);
        end else begin
          if (tx_push) wp_b <= wp_b + 4'h1;
          if (do_pop) rp_b <= rp_b + 4'h1;
          cnt_b <= cnt_b + `CNT_W'(tx_push) - `CNT_W'(do_pop);
        end
      end else begin
        if (rx_push) wp_b <= wp_b + 4'h1;
        if (rx_rd) rp_b <= rp_b + 4'h1;
        cnt_b <= cnt_b + `CNT_W'(rx_push) - `CNT_W'(rx_rd);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (tx_push && !tx_is_b) mem_a[wp_a] <= pwdata[7:0];
    if (rx_push && tx_is_b)  mem_a[wp_a] <= bus_rx_byte;
    if (tx_push && tx_is_b)  mem_b[wp_b] <= pwdata[7:0];
    if (rx_push && !tx_is_b) mem_b[wp_b] <= bus_rx_byte;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_data <= '0;
    end else begin
      tx_data <= tx_is_b ? mem_b[rp_b] : mem_a[rp_a];
    end
  end
  assign tx_avail = if_enable && tx_on && (tx_cnt != '0) && !read_ptr_restore;

  // ****************************************************************
  // Receive idle detection
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      idle_bits <= '0;
      idle_seen <= 1'b0;
    end else begin
      if (!rx_on || !rx_idle_detect_on || rx_push || rx_rd || rx_cnt == '0) begin
        idle_bits <= '0;
        if (rx_rd || rx_cnt == '0 || !rx_on) idle_seen <= 1'b0;
      end else if (bit_tick) begin
        if (idle_bits == `IDLE_BIT_TIMES) begin
          idle_seen <= 1'b1;
        end else begin
          idle_bits <= idle_bits + 4'd1;
        end
      end
    end
  end
  assign rx_irq = idle_seen && rx_irq_on;

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (hit(`ADDR_MASK_OFS)) begin
        prdata <= {24'h00_0000, if_enable, addr_compare_mask};
      end else if (hit(`OWN_ADDR_OFS)) begin
        prdata <= {24'h00_0000, own_addr_detect_on, own_addr_value};
      end else if (hit(`BAUD_OFS)) begin
        prdata <= {17'h0_0000, baud_value};
      end else if (hit(`FIFO_UPPER_OFS)) begin
        prdata <= {27'h000_0000, lost_detect_on, rx_idle_detect_on,
                   tx_refill_request, tx_refill_irq_on, fifo_role_select};
      end else if (hit(`FIFO_LOWER_OFS)) begin
        prdata <= {25'h000_0000, retx_lost_flag, read_ptr_restore, 3'b000,
                   fifo_b_on, fifo_a_on};
      end else if (hit(`CTRL_OFS)) begin
        prdata <= {31'h0000_0000, rx_irq_on};
      end else if (hit(`STATUS_OFS)) begin
        prdata <= {12'h000, 3'b000, rx_cnt, 3'b000, tx_cnt, 2'b00,
                   bus_error_flag, slave_active};
      end else if (hit(`RXRD_OFS)) begin
        prdata <= {24'h00_0000, tx_is_b ? mem_a[rp_a] : mem_b[rp_b]};
      end else begin
        prdata <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/i2c_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts for the I2C control block
`ifndef I2C_CTRL_MAP_SVH
`define I2C_CTRL_MAP_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ADDR_MASK_OFS     12'h000
`define OWN_ADDR_OFS      12'h004
`define BAUD_OFS          12'h008
`define FIFO_UPPER_OFS    12'h00C
`define FIFO_LOWER_OFS    12'h010
`define CTRL_OFS          12'h014
`define STATUS_OFS        12'h018
`define TXWR_OFS          12'h01C
`define RXRD_OFS          12'h020

// ****************************************************************
// Field positions
// ****************************************************************
`define MASK_ENABLE_BIT   7
`define OWN_DETECT_BIT    7
`define UP_LOST_ON_BIT    4
`define UP_IDLE_ON_BIT    3
`define UP_REFILL_BIT     2
`define UP_IRQ_ON_BIT     1
`define UP_ROLE_BIT       0
`define LO_LOST_BIT       6
`define LO_RESTORE_BIT    5
`define LO_SAVE_BIT       4
`define LO_CLEAR_B_BIT    3
`define LO_CLEAR_A_BIT    2
`define LO_ON_B_BIT       1
`define LO_ON_A_BIT       0

// ****************************************************************
// Reset values, sizes and timing counts
// ****************************************************************
`define MASK_RESET        8'h7F
`define UPPER_RESET       5'h04
`define FIFO_DEPTH        16
`define PTR_W             4
`define CNT_W             5
`define IDLE_BIT_TIMES    4'h8
`define TICKS_PER_BIT     2'h3
`endif

// ===== rtl/i2c_ctrl_pkg.sv
// Types shared by the I2C control block
package i2c_ctrl_pkg;
  typedef enum logic [1:0] {
    idle_st = 2'b00,
    addr_st = 2'b01,
    slave_st = 2'b11
  } addr_state_t;
endpackage

// ===== test/i2c_ctrl_asserts.sv
// Port-level assertions for the I2C control block
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_map.svh"
module i2c_ctrl_asserts (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        bus_byte_done,
  input wire logic        bus_error_flag,
  input wire logic        addr_ack,
  input wire logic        slave_active,
  input wire logic        serial_tick,
  input wire logic        link_run,
  input wire logic        tx_irq
);
  logic        wr_go;
  logic        detect_on;
  logic [14:0] baud_val;
  logic [14:0] gap;
  logic        gap_ok;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  assign wr_go = psel && penable && pwrite;
  // ****************************************
  // Shadows, so no check peeks into the body
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      detect_on <= 1'b0;
      baud_val  <= 15'h0000;
    end else if (wr_go && paddr == `OWN_ADDR_OFS) begin
      detect_on <= pwdata[`OWN_DETECT_BIT];
    end else if (wr_go && paddr == `BAUD_OFS) begin
      baud_val <= pwdata[14:0];
    end
  end
  // First gap after a divider write or enable is not judged: its phase is free
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap    <= 15'h0000;
      gap_ok <= 1'b0;
    end else if ((wr_go && paddr == `BAUD_OFS) || !link_run) begin
      gap    <= 15'h0000;
      gap_ok <= 1'b0;
    end else if (serial_tick) begin
      gap    <= 15'h0000;
      gap_ok <= 1'b1;
    end else begin
      gap <= gap + 15'h0001;
    end
  end
  property p_err_keeps_on;
    bus_error_flag && link_run && !(wr_go && paddr == `ADDR_MASK_OFS) |=> link_run;
  endproperty
  a_err_keeps_on: assert property (p_err_keeps_on) else $error("enable lost on bus error");
  property p_off_stops;
    wr_go && paddr == `ADDR_MASK_OFS && !pwdata[`MASK_ENABLE_BIT] |=> !link_run && !slave_active;
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("link still runs after disable");
  property p_ack_pulse;
    addr_ack |=> !addr_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_slave;
    addr_ack |-> ##[0:1] slave_active;
  endproperty
  a_ack_slave: assert property (p_ack_slave) else $error("match without slave mode");
  property p_ack_cause;
    addr_ack |-> $past(bus_byte_done) && link_run;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without a received byte");
  property p_no_detect;
    !detect_on |-> !addr_ack;
  endproperty
  a_no_detect: assert property (p_no_detect) else $error("ack with detection off");
  property p_irq_off;
    wr_go && paddr == `FIFO_UPPER_OFS && !pwdata[`UP_IRQ_ON_BIT] |=> !tx_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("tx irq with enable off");
  property p_tick_gap;
    serial_tick && gap_ok |-> gap == baud_val;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("divider period wrong");
  c_ack: cover property (addr_ack);
  c_tick: cover property (serial_tick && gap_ok);
  c_irq: cover property (tx_irq);
endmodule
bind i2c_addr_baud_fifo_ctrl i2c_ctrl_asserts i_chk (.mclk(mclk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .bus_byte_done(bus_byte_done), .bus_error_flag(bus_error_flag), .addr_ack(addr_ack),
  .slave_active(slave_active), .serial_tick(serial_tick), .link_run(link_run),
  .tx_irq(tx_irq));
`default_nettype wire

// ===== test/i2c_far_end.sv
// Bus-engine stand-in: start, one received byte, error level and transmit pops
`timescale 1ns/1ps
`default_nettype none
module i2c_far_end (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       send,
  input  wire logic [7:0] byte_in,
  input  wire logic       err_in,
  input  wire logic       pop_in,
  input  wire logic       byte_only,
  output logic            bus_start,
  output logic            bus_byte_done,
  output logic      [7:0] bus_rx_byte,
  output logic            bus_error_flag,
  output logic            tx_pop
);
  logic [1:0] stage;
  // ****************************************
  // Frame sequencing
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage         <= 2'b00;
      bus_start     <= 1'b0;
      bus_byte_done <= 1'b0;
      tx_pop        <= 1'b0;
    end else begin
      stage         <= {stage[0], send};
      bus_start     <= send;
      // A byte with no start in front is a data byte for slave mode
      bus_byte_done <= stage[1] | byte_only;
      tx_pop        <= pop_in;
    end
  end
  // Outside its slot the byte line toggles, so a stale byte never looks fresh
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rx_byte    <= 8'h00;
      bus_error_flag <= 1'b0;
    end else begin
      bus_rx_byte    <= (stage[1] | byte_only) ? byte_in : ~bus_rx_byte;
      bus_error_flag <= err_in;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the I2C control block
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ctrl_map.svh"
module tb;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q;} row_t;
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, e, hit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        bus_start, bus_byte_done, bus_error_flag, tx_pop, send, err_in, pop_in, byte_only;
  logic [7:0]  bus_rx_byte, byte_in, tx_data;
  logic        tx_avail, addr_ack, slave_active, serial_tick, link_run, tx_irq, rx_irq;
  int          err_count, num_checks, n;
  row_t        rows[7] = '{
    '{`ADDR_MASK_OFS, 32'h0000_002A, 32'h0000_002A},
    '{`OWN_ADDR_OFS, 32'h0000_0055, 32'h0000_0055},
    '{`BAUD_OFS, 32'h0000_FFFF, 32'h0000_7FFF},
    '{`BAUD_OFS, 32'h0000_1234, 32'h0000_1234},
    '{`FIFO_UPPER_OFS, 32'h0000_000B, 32'h0000_000F},
    '{`FIFO_UPPER_OFS, 32'h0000_0000, 32'h0000_0004},
    '{`FIFO_LOWER_OFS, 32'h0000_001C, 32'h0000_0000}};
  // Mask, own address, byte on the bus, ack wanted; 0x55 is not a reserved address
  logic [24:0] arow[4] = '{{8'h7F, 8'hD5, 8'hAA, 1'b1}, {8'h7E, 8'hD5, 8'hA8, 1'b1},
    {8'h7E, 8'hD5, 8'hAC, 1'b0}, {8'h7F, 8'h55, 8'hAA, 1'b0}};
  i2c_addr_baud_fifo_ctrl i_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_start(bus_start), .bus_byte_done(bus_byte_done),
    .bus_rx_byte(bus_rx_byte), .bus_error_flag(bus_error_flag), .tx_pop(tx_pop),
    .tx_data(tx_data), .tx_avail(tx_avail), .addr_ack(addr_ack), .slave_active(slave_active),
    .serial_tick(serial_tick), .link_run(link_run), .tx_irq(tx_irq), .rx_irq(rx_irq));
  i2c_far_end i_far (.mclk(mclk), .reset_n(reset_n), .send(send), .byte_in(byte_in),
    .err_in(err_in), .pop_in(pop_in), .bus_start(bus_start), .bus_byte_done(bus_byte_done),
    .bus_rx_byte(bus_rx_byte), .bus_error_flag(bus_error_flag), .tx_pop(tx_pop),
    .byte_only(byte_only));
  // ****************************************
  // Bus tasks and reporting
  // ****************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
  endtask
  // Entered just after an edge; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    rd_q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_q, exp);
  endtask
  task automatic probe(input logic [7:0] b, input logic exp);
    send <= 1'b1;
    byte_in <= b;
    @(posedge mclk);
    send <= 1'b0;
    hit = 1'b0;
    repeat (8) begin
      @(posedge mclk);
      hit = hit | addr_ack;
    end
    chk({31'h0, hit}, {31'h0, exp});
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    {reset_n, psel, penable, pwrite, send, err_in, pop_in, byte_only} = 8'h00;
    {paddr, pwdata, byte_in} = 52'h0;
    err_count = 0;
    num_checks = 0;
    tick(20);
    reset_n <= 1'b1;
    @(posedge mclk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q);
    end
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(`ADDR_MASK_OFS, `MASK_RESET);
    rd(`OWN_ADDR_OFS, 32'h0000_0000);
    rd(`FIFO_UPPER_OFS, 32'h0000_0004);
    rd(`FIFO_LOWER_OFS, 32'h0000_0000);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    chk(rd_q, 32'h0000_0000);
    // 25 cycles per expiry, 4 per bit: 400 kbps at 40 MHz
    wr(`BAUD_OFS, 32'h0000_0018);
    foreach (arow[i]) begin
      wr(`ADDR_MASK_OFS, {24'h0, arow[i][24:17]});
      wr(`OWN_ADDR_OFS, {24'h0, arow[i][16:9]});
      wr(`ADDR_MASK_OFS, {24'h0, 1'b1, arow[i][23:17]});
      probe(arow[i][8:1], arow[i][0]);
    end
    n = 0;
    repeat (100) begin
      @(posedge mclk);
      n += serial_tick;
    end
    chk(n, 32'h0000_0004);
    err_in <= 1'b1;
    tick(4);
    chk({31'h0, link_run}, 32'h0000_0001);
    err_in <= 1'b0;
    wr(`ADDR_MASK_OFS, 32'h0000_007F);
    chk({31'h0, link_run}, 32'h0000_0000);
    wr(`ADDR_MASK_OFS, 32'h0000_00FF);
    wr(`FIFO_UPPER_OFS, 32'h0000_0002);
    chk({31'h0, tx_irq}, 32'h0000_0001);
    wr(`FIFO_LOWER_OFS, 32'h0000_0001);
    wr(`TXWR_OFS, 32'h0000_00A5);
    tick(2);
    chk({23'h0, tx_avail, tx_data}, 32'h0000_01A5);
    wr(`FIFO_UPPER_OFS, 32'h0000_0002);
    rd(`FIFO_UPPER_OFS, 32'h0000_0002);
    chk({31'h0, tx_irq}, 32'h0000_0000);
    // Role change while no refill is pending must be refused
    wr(`FIFO_LOWER_OFS, 32'h0000_0000);
    wr(`FIFO_UPPER_OFS, 32'h0000_0003);
    rd(`FIFO_UPPER_OFS, 32'h0000_0002);
    wr(`FIFO_LOWER_OFS, 32'h0000_0001);
    pop_in <= 1'b1;
    @(posedge mclk);
    pop_in <= 1'b0;
    tick(3);
    rd(`FIFO_UPPER_OFS, 32'h0000_0006);
    wr(`FIFO_LOWER_OFS, 32'h0000_0011);
    rd(`FIFO_LOWER_OFS, 32'h0000_0001);
    wr(`FIFO_UPPER_OFS, 32'h0000_0010);
    wr(`TXWR_OFS, 32'h0000_003C);
    rd(`FIFO_LOWER_OFS, 32'h0000_0041);
    wr(`FIFO_LOWER_OFS, 32'h0000_0020);
    rd(`FIFO_LOWER_OFS, 32'h0000_0040);
    wr(`FIFO_LOWER_OFS, 32'h0000_0004);
    rd(`FIFO_LOWER_OFS, 32'h0000_0000);
    rd(`FIFO_UPPER_OFS, 32'h0000_0014);
    wr(`FIFO_LOWER_OFS, 32'h0000_0020);
    tick(2);
    rd(`FIFO_LOWER_OFS, 32'h0000_0000);
    // Receive one data byte in slave mode, then let the link sit idle
    wr(`ADDR_MASK_OFS, 32'h0000_007F);
    wr(`OWN_ADDR_OFS, 32'h0000_00D5);
    wr(`ADDR_MASK_OFS, 32'h0000_00FF);
    wr(`CTRL_OFS, 32'h0000_0001);
    wr(`FIFO_UPPER_OFS, 32'h0000_0008);
    wr(`FIFO_LOWER_OFS, 32'h0000_0002);
    probe(8'hAA, 1'b1);
    byte_only <= 1'b1;
    byte_in <= 8'h3C;
    @(posedge mclk);
    byte_only <= 1'b0;
    // A bit is 100 cycles: under 8 bit times no idle yet, past 9 it must show
    tick(750);
    chk({31'h0, rx_irq}, 32'h0000_0000);
    tick(250);
    chk({31'h0, rx_irq}, 32'h0000_0001);
    rd(`RXRD_OFS, 32'h0000_003C);
    chk({31'h0, rx_irq}, 32'h0000_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
